// file: rtl/dbl_pkg.sv
/*
 package for the double-buffered converter load block: sizes, reset values, carrier structs.
 assumes a single system clock and a synchronous active-high reset.
*/
package dbl_pkg;
    localparam int          DBL_NCH       = 12;
    localparam int          DBL_CW        = 12;
    localparam int          DBL_AW        = 4;
    localparam logic [11:0] DBL_CODE_RST  = 12'h000;
    localparam logic [11:0] DBL_SEL_RST   = 12'h000;
    localparam logic [11:0] DBL_GAIN_RST  = 12'h000;
    localparam logic [11:0] DBL_PWR_RST   = 12'h000;
    localparam logic [11:0] DBL_PEND_RST  = 12'h000;

    typedef logic [DBL_CW-1:0] dbl_code_t;

    typedef struct packed {
        logic            wr;
        logic            rd;
        logic [DBL_AW-1:0] ch;
        dbl_code_t       data;
    } dbl_req_s;

    typedef struct packed {
        logic      valid;
        dbl_code_t data;
    } dbl_rsp_s;

    typedef enum logic [1:0] {
        DBL_IDLE  = 2'b00,
        DBL_FIRE  = 2'b01,
        DBL_ARMED = 2'b11
    } dbl_trig_e;
endpackage : dbl_pkg

// file: rtl/dbl_trig.sv
/*
 load trigger strobe: turns a write of one to the load trigger bit into a one-cycle pulse.
 assumes the write strobe is synchronous to CLK_SYS_I.
*/
`timescale 1ns/1ns
`default_nettype none
module dbl_trig
    import dbl_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic trig_wr_i,
    output var  logic load_pulse_o,
    output var  logic trig_bit_o
);
    dbl_trig_e state_r;
    dbl_trig_e state_nxt;

    always_comb begin
        case (state_r)
            DBL_IDLE:  state_nxt = trig_wr_i ? DBL_FIRE : DBL_IDLE;
            DBL_FIRE:  state_nxt = trig_wr_i ? DBL_FIRE : DBL_IDLE;
            default:   state_nxt = DBL_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r <= DBL_IDLE;
        end else begin
            state_r <= state_nxt; // R13
        end
    end

    // one pulse per write; back-to-back writes each fire
    assign load_pulse_o = (state_r == DBL_FIRE); // R7
    // self-clearing: bit never stores a one
    assign trig_bit_o   = 1'b0; // R13
endmodule : dbl_trig
`default_nettype wire

// file: rtl/dbl_load.sv
/*
 double-buffered load control for twelve 12-bit converter channels.
 assumes the serial register front end presents single-cycle write/read strobes on CLK_SYS_I.
*/
// What this block does
// R1: twelve channels, each holding a 12-bit output code.
// R2: input code register feeds output latch; only latch drives output.
// R3: latch copies input register only on internal load pulse.
// R4: writes land in input register; output changes when latch updates.
// R5: reading a channel returns its latch value, not the pending input.
// R6: latch stays unchanged after write until load pulse fires.
// R7: writing one to load trigger bit generates the internal load pulse.
// R8: per-channel gain bit selects zero to twice reference full scale.
// R9: output buffers power up disabled, high-impedance, until software enables.
// R10: reset forces all input registers and latches to zero.
// R11: only sync-load-selected channels update, all in the same cycle.
// R12: only channels written since their own last load reload.
// R13: load trigger bit is a self-clearing single-cycle strobe.
`timescale 1ns/1ns
`default_nettype none
module dbl_load
    import dbl_pkg::*;
(
    input  wire logic                   CLK_SYS_I,
    input  wire logic                   SRST_I,
    input  wire dbl_req_s               REQ_I,
    output var  dbl_rsp_s               RSP_O,
    input  wire logic                   LOAD_TRIG_WR_I,
    output var  logic                   LOAD_TRIG_BIT_O,
    input  wire logic [DBL_NCH-1:0]     SYNC_LOAD_SELECT_I,
    input  wire logic [DBL_NCH-1:0]     GAIN_SEL_I,
    input  wire logic [DBL_NCH-1:0]     BUF_ENABLE_I,
    output var  logic [DBL_NCH*DBL_CW-1:0] CHANNEL_CODE_O,
    output var  logic [DBL_NCH-1:0]     CHANNEL_GAIN2X_O,
    output var  logic [DBL_NCH-1:0]     CHANNEL_PWRDN_N_O,
    output var  logic                   LOAD_PULSE_O
);

    // two stages per channel: input code, then the latch that drives the output
    dbl_code_t          in_r        [DBL_NCH]; // R1
    dbl_code_t          in_nxt      [DBL_NCH];
    dbl_code_t          latch_r     [DBL_NCH];
    dbl_code_t          latch_nxt   [DBL_NCH];
    logic [DBL_NCH-1:0] pend_r;
    logic [DBL_NCH-1:0] pend_nxt;
    logic [DBL_NCH-1:0] gain_r;
    logic [DBL_NCH-1:0] gain_nxt;
    logic [DBL_NCH-1:0] pwr_r;
    logic [DBL_NCH-1:0] pwr_nxt;
    logic [DBL_NCH-1:0] wr_sel;
    logic [DBL_NCH-1:0] rd_sel;
    logic [DBL_NCH-1:0] clr_sel;
    logic [DBL_NCH-1:0] load_en;
    logic               load_pulse;
    logic               ch_ok;
    dbl_code_t          rd_code;
    dbl_rsp_s           rsp_nxt;
    logic               rsp_valid_r;
    dbl_code_t          rsp_data_r;

    // true when the request index names channel n
    function automatic logic hit(input logic [DBL_AW-1:0] a, input int n);
        hit = (32'(a) == n);
    endfunction : hit

    // index to one-hot; indices past the last channel select nothing
    function automatic logic [DBL_NCH-1:0] ch_dec(input logic [DBL_AW-1:0] a, input logic en);
        ch_dec = '0;
        for (int n = 0; n < DBL_NCH; n++) begin
            if (en && hit(a, n)) begin
                ch_dec[n] = 1'b1;
            end
        end
    endfunction : ch_dec

    // indices 12..15 are reserved: writes dropped, reads return zero
    assign ch_ok  = (32'(REQ_I.ch) < DBL_NCH);
    assign wr_sel = ch_dec(REQ_I.ch, REQ_I.wr);
    assign rd_sel = ch_dec(REQ_I.ch, REQ_I.rd && ch_ok);

    // strobe kept in its own module so the bit itself never stores a one
    dbl_trig u_trig (
        .clk_i        (CLK_SYS_I),
        .srst_i       (SRST_I),
        .trig_wr_i    (LOAD_TRIG_WR_I), // R7
        .load_pulse_o (load_pulse),
        .trig_bit_o   (LOAD_TRIG_BIT_O) // R13
    );
    assign LOAD_PULSE_O = load_pulse;

    // a channel moves only if selected and written since its last load
    assign clr_sel = load_pulse ? SYNC_LOAD_SELECT_I : '0; // R11
    assign load_en = clr_sel & pend_r; // R11 R12

    // host writes only touch the input stage
    always_comb begin
        for (int n = 0; n < DBL_NCH; n++) begin
            in_nxt[n] = in_r[n];
            if (wr_sel[n]) begin
                in_nxt[n] = REQ_I.data; // R4
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        for (int n = 0; n < DBL_NCH; n++) begin
            if (SRST_I) begin
                in_r[n] <= DBL_CODE_RST; // R10
            end else begin
                in_r[n] <= in_nxt[n];
            end
        end
    end

    // written-since-last-load flags; set wins over the clearing pulse
    always_comb begin
        for (int n = 0; n < DBL_NCH; n++) begin
            pend_nxt[n] = pend_r[n];
            if (wr_sel[n]) begin
                pend_nxt[n] = 1'b1; // R12
            end else if (clr_sel[n]) begin
                pend_nxt[n] = 1'b0; // R12
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            pend_r <= DBL_PEND_RST;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // all enabled channels move together on the one pulse
    always_comb begin
        for (int n = 0; n < DBL_NCH; n++) begin
            latch_nxt[n] = latch_r[n];
            if (load_en[n]) begin
                latch_nxt[n] = in_r[n]; // R3 R6 R11
            end
        end
    end

    // latch is the only stage the converter sees
    always_ff @(posedge CLK_SYS_I) begin
        for (int n = 0; n < DBL_NCH; n++) begin
            if (SRST_I) begin
                latch_r[n] <= DBL_CODE_RST; // R10
            end else begin
                latch_r[n] <= latch_nxt[n]; // R2
            end
        end
    end

    // gain and buffer enable are levels; one flop keeps the outputs registered
    always_comb begin
        gain_nxt = GAIN_SEL_I; // R8
        pwr_nxt  = BUF_ENABLE_I; // R9
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            gain_r <= DBL_GAIN_RST;
        end else begin
            gain_r <= gain_nxt; // R8
        end
    end

    // buffers come up powered down until software enables them
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            pwr_r <= DBL_PWR_RST; // R9
        end else begin
            pwr_r <= pwr_nxt; // R9
        end
    end

    // readback shows the latch, never the pending code
    always_comb begin
        rd_code = DBL_CODE_RST;
        for (int n = 0; n < DBL_NCH; n++) begin
            if (rd_sel[n]) begin
                rd_code = latch_r[n]; // R5
            end
        end
    end

    // data is zero unless an in-range read is taken
    always_comb begin
        rsp_nxt       = '0;
        rsp_nxt.valid = REQ_I.rd;
        rsp_nxt.data  = rd_code; // R5
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= rsp_nxt.valid; // R5
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            rsp_data_r <= DBL_CODE_RST;
        end else begin
            rsp_data_r <= rsp_nxt.data; // R5
        end
    end

    always_comb begin
        RSP_O       = '0;
        RSP_O.valid = rsp_valid_r;
        RSP_O.data  = rsp_data_r;
    end

    // flatten latches; channel n sits at bits 12n+11:12n
    always_comb begin
        for (int n = 0; n < DBL_NCH; n++) begin
            CHANNEL_CODE_O[n*DBL_CW +: DBL_CW] = latch_r[n]; // R2
        end
    end
    assign CHANNEL_GAIN2X_O  = gain_r; // R8
    assign CHANNEL_PWRDN_N_O = pwr_r; // R9
endmodule : dbl_load
`default_nettype wire

// file: tb/dbl_load_assertions.sv
/* port checker for dbl_load.
 assumes it is bound onto every dbl_load instance. */
`timescale 1ns/1ns
`default_nettype none
module dbl_load_chk
    import dbl_pkg::*;
(
    input wire logic           CLK_SYS_I,
    input wire logic           SRST_I,
    input wire dbl_req_s       REQ_I,
    input wire dbl_rsp_s       RSP_O,
    input wire logic           LOAD_TRIG_WR_I,
    input wire logic           LOAD_TRIG_BIT_O,
    input wire logic [11:0]    SYNC_LOAD_SELECT_I,
    input wire logic [11:0]    GAIN_SEL_I,
    input wire logic [11:0]    BUF_ENABLE_I,
    input wire logic [143:0]   CHANNEL_CODE_O,
    input wire logic [11:0]    CHANNEL_GAIN2X_O,
    input wire logic [11:0]    CHANNEL_PWRDN_N_O,
    input wire logic           LOAD_PULSE_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (SRST_I);
    pulse_follows_a: assert property (!SRST_I && LOAD_TRIG_WR_I |=> LOAD_PULSE_O) else $error("no pulse");
    pulse_cause_a: assert property (LOAD_PULSE_O |-> $past(LOAD_TRIG_WR_I)) else $error("stray pulse");
    trig_clear_a: assert property (!LOAD_TRIG_BIT_O) else $error("trigger bit set");
    rsp_due_a: assert property (!SRST_I && REQ_I.rd |=> RSP_O.valid) else $error("no reply");
    rsp_cause_a: assert property (RSP_O.valid |-> $past(REQ_I.rd)) else $error("stray reply");
    latch_hold_a: assert property (!LOAD_PULSE_O |=> $stable(CHANNEL_CODE_O)) else $error("latch moved");
    gain_follow_a: assert property (!SRST_I |=> CHANNEL_GAIN2X_O == $past(GAIN_SEL_I)) else $error("gain");
    pwr_follow_a: assert property (!SRST_I |=> CHANNEL_PWRDN_N_O == $past(BUF_ENABLE_I)) else $error("pwr");
    rst_zero_a: assert property (disable iff (1'b0) SRST_I |=> CHANNEL_CODE_O == '0 && CHANNEL_PWRDN_N_O == '0)
        else $error("reset state");
    cover property (LOAD_PULSE_O && SYNC_LOAD_SELECT_I != '0);
    cover property (RSP_O.valid && RSP_O.data != '0);
    cover property (REQ_I.wr && REQ_I.ch > 4'hb);
endmodule : dbl_load_chk
bind dbl_load dbl_load_chk u_dbl_load_chk (.*);
`default_nettype wire

// file: tb/dbl_load_tb.sv
/* random self-checking bench for dbl_load.
 assumes only the package and the design. */
`timescale 1ns/1ns
`default_nettype none
module dbl_load_tb
    import dbl_pkg::*;
;
    logic clk = 0, srst = 1, trig = 0, tbit, pulse;
    dbl_req_s req = '0;
    dbl_rsp_s rsp;
    logic [11:0] sel = '0, gain = '0, ben = '0, gx, pn, pend = '0;
    logic [143:0] code;
    logic [11:0] in_m[12], lat_m[12];
    int miscompares = 0, checks_done = 0, cyc = 0, seed = 32'h5de4, ch;
    dbl_load u_dbl_load (.CLK_SYS_I(clk), .SRST_I(srst), .REQ_I(req), .RSP_O(rsp), .LOAD_TRIG_WR_I(trig),
        .LOAD_TRIG_BIT_O(tbit), .SYNC_LOAD_SELECT_I(sel), .GAIN_SEL_I(gain), .BUF_ENABLE_I(ben),
        .CHANNEL_CODE_O(code), .CHANNEL_GAIN2X_O(gx), .CHANNEL_PWRDN_N_O(pn), .LOAD_PULSE_O(pulse));
    initial forever #5 clk = ~clk;
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [143:0] e, input logic [143:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    function automatic logic [143:0] exp_code();
        for (int i = 0; i < 12; i++) exp_code[i*12 +: 12] = lat_m[i];
    endfunction : exp_code
    // one op per call, then idle long enough for the latch to settle
    task automatic step(input int op, input logic [11:0] s);
        @(posedge clk);
        #1;
        sel = s;
        gain = 12'($random(seed));
        ben = 12'($random(seed));
        ch = $unsigned($random(seed)) % 14;
        req.ch = ch[3:0];
        if (op == 0) begin
            req.wr = 1;
            req.data = 12'($random(seed));
            if (ch < 12) begin
                in_m[ch] = req.data;
                pend[ch] = 1;
            end
        end else if (op == 1) begin
            trig = 1;
            for (int i = 0; i < 12; i++) if (s[i] && pend[i]) begin
                lat_m[i] = in_m[i];
                pend[i] = 0;
            end
        end else req.rd = 1;
        @(posedge clk);
        #1;
        if (op == 2) chk("read", {1'b1, ch < 12 ? lat_m[ch] : 12'h000}, rsp);
        chk("pulse", op == 1, pulse);
        chk("trig bit", '0, tbit);
        req.wr = 0;
        req.rd = 0;
        trig = 0;
        repeat (3) @(posedge clk);
        #1;
        chk("code", exp_code(), code);
        chk("gain", gain, gx);
        chk("power", ben, pn);
    endtask : step
    initial begin
        for (int i = 0; i < 12; i++) begin
            in_m[i] = 0;
            lat_m[i] = 0;
        end
        repeat (8) @(posedge clk);
        #1 srst = 0;
        chk("reset code", '0, code);
        chk("reset power", '0, pn);
        $display("reset test done");
        step(0, 12'h000);
        step(1, 12'h000);
        step(1, 12'hfff);
        step(1, 12'hfff);
        for (int k = 0; k < 150; k++) step($unsigned($random(seed)) % 3, 12'($random(seed)));
        $display("random test done");
        end_sim();
    end
endmodule : dbl_load_tb
`default_nettype wire
